// ==== logic/dwc_config_top.sv ====
// Purpose: Watchdog, detection and supply config registers behind an addressed serial port
// Assumes: Serial pins and comparator levels are synchronous to core_clk
// Notes:   Frame is 16 bits: chip[1:0], reg[4:0], write, data[7:0]; msb first
`default_nettype none

// Functional notes
// - Timeout code 00 off, else 200/600/1200 ms
// - Sync enable bit gates sync watchdog
// - Serial watchdog off: sync uses fixed 600 ms
// - Two-bit off-state detect current select
// - Short-to-supply threshold code 9/10/12/14 V
// - High undervoltage bit selects higher thresholds
// - Supplies above threshold: supply-ok low, channels on
// - Threshold bit affects level bits only if source set
// - Input type bit: 0 type 1/3, 1 type 2
// - Reserved input config bit stays zero
// - Source select: pin levels or supply faults
module dwc_config_top
    import dwc_pkg::*;
#(
    parameter logic [WD_CNT_W-1:0] WD_SHORT = WD_CNT_W'(WD_SHORT_CYCLES),
    parameter logic [WD_CNT_W-1:0] WD_MID = WD_CNT_W'(WD_MID_CYCLES),
    parameter logic [WD_CNT_W-1:0] WD_LONG = WD_CNT_W'(WD_LONG_CYCLES)
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Serial port
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe_n,
    input wire logic [1:0] chip_addr,
    // Sync pin
    input wire logic sync_input_pin,
    // Supply comparators and channel pins
    input wire logic main_above_normal,
    input wire logic main_above_high,
    input wire logic [3:0] chan_above_normal,
    input wire logic [3:0] chan_above_high,
    input wire logic [3:0] channel_pin,
    // Supply status
    output logic supply_ok_output_n,
    output logic [3:0] channel_on,
    // Watchdog status
    output logic spi_watchdog_expired,
    output logic sync_watchdog_expired,
    // Configuration to analog and channel logic
    output logic [1:0] offstate_detect_current_select,
    output logic [1:0] short_supply_threshold_select,
    output logic high_uv_threshold_enable,
    output logic input_type_select,
    output logic supply_fault_mask,
    output logic overrange_protect_enable,
    output logic overload_stretch_enable,
    output logic [1:0] overload_blanking_select
);

    // ============================================================
    // Serial frame receiver
    // ============================================================
    logic sclk_prev, next_sclk_prev;     // Last sclk level for edge detect
    logic cs_prev, next_cs_prev;         // Last chip select level
    logic [4:0] bit_cnt, next_bit_cnt;   // Bits taken in this frame
    logic [15:0] shift_in, next_shift_in;
    logic [7:0] tx, next_tx;             // Read data being shifted out
    logic next_miso, next_miso_oe_n;
    logic commit, next_commit;           // One-cycle pulse: full frame for us
    dwc_frame_t frame;                   // Frame view of the shift register
    dwc_frame_t head;                    // First byte view after eight bits
    logic [7:0] rdata;                   // Read mux output
    logic sclk_rise, sclk_fall;

    // Configuration registers
    dwc_cfg2_t cfg2, next_cfg2;
    dwc_cfgdi_t cfgdi, next_cfgdi;
    logic [3:0] level, next_level;       // Channel level register content

    assign frame = dwc_frame_t'(shift_in);
    assign head = dwc_frame_t'({next_shift_in[7:0], 8'h00});

    // Read mux, unmapped addresses read zero
    always_comb begin
        case (head.reg_addr)
            CFG2_OFS: rdata = cfg2;
            CFGDI_OFS: rdata = cfgdi;
            LEVEL_OFS: rdata = {4'h0, level};
            default: rdata = 8'h00;
        endcase
    end

    // Frame next-state: sample on rising sclk, shift out on falling
    always_comb begin
        sclk_rise = spi_sclk && !sclk_prev;
        sclk_fall = !spi_sclk && sclk_prev;
        next_sclk_prev = spi_sclk;
        next_cs_prev = spi_cs_n;
        next_bit_cnt = bit_cnt;
        next_shift_in = shift_in;
        next_tx = tx;
        next_miso = spi_miso;
        next_miso_oe_n = spi_miso_oe_n;
        next_commit = 1'b0;
        if (spi_cs_n) begin
            // Idle: release the shared data-out line
            next_bit_cnt = '0;
            next_miso_oe_n = 1'b1;
            next_miso = 1'b0;
            // Frame ends on chip select rise; short frames are dropped, bits past the sixteenth are ignored
            if (!cs_prev && bit_cnt == 5'd16 && frame.chip == chip_addr) begin
                next_commit = 1'b1;
            end
        end else begin
            if (sclk_rise && bit_cnt != 5'd16) begin
                next_shift_in = {shift_in[14:0], spi_mosi};
                next_bit_cnt = bit_cnt + 5'd1;
                // After the command byte, load read data if addressed to us
                if (bit_cnt == 5'd7 && head.chip == chip_addr) begin
                    next_tx = rdata;
                    next_miso_oe_n = 1'b0;
                end
            end else if (sclk_fall && bit_cnt >= 5'd8 && !spi_miso_oe_n) begin
                next_miso = tx[7];
                next_tx = {tx[6:0], 1'b0};
            end
        end
    end

    // Frame registers
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sclk_prev <= 1'b0;
            cs_prev <= 1'b1;
            bit_cnt <= '0;
            shift_in <= '0;
            tx <= '0;
            spi_miso <= 1'b0;
            spi_miso_oe_n <= 1'b1;
            commit <= 1'b0;
        end else begin
            sclk_prev <= next_sclk_prev;
            cs_prev <= next_cs_prev;
            bit_cnt <= next_bit_cnt;
            shift_in <= next_shift_in;
            tx <= next_tx;
            spi_miso <= next_miso;
            spi_miso_oe_n <= next_miso_oe_n;
            commit <= next_commit;
        end
    end

    // ============================================================
    // Configuration registers
    // ============================================================
    // Write on a committed frame; values otherwise held
    always_comb begin
        next_cfg2 = cfg2;
        next_cfgdi = cfgdi;
        if (commit && frame.write) begin
            case (frame.reg_addr)
                CFG2_OFS: next_cfg2 = dwc_cfg2_t'(frame.data);
                CFGDI_OFS: begin
                    next_cfgdi = dwc_cfgdi_t'(frame.data);
                    // Reserved bit forced low, whatever the host sends
                    next_cfgdi.reserved = 1'b0;
                end
                default: begin
                    // Level register and unmapped writes are ignored
                    next_cfg2 = cfg2;
                end
            endcase
        end
    end

    // Configuration register flops
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cfg2 <= dwc_cfg2_t'(CFG2_RESET);
            cfgdi <= dwc_cfgdi_t'(CFGDI_RESET);
        end else begin
            cfg2 <= next_cfg2;
            cfgdi <= next_cfgdi;
        end
    end

    // Field outputs straight from the config flops
    assign offstate_detect_current_select = cfg2.offstate_detect_current_select;
    assign short_supply_threshold_select = cfg2.short_supply_threshold_select;
    assign high_uv_threshold_enable = cfg2.high_uv_threshold_enable;
    assign input_type_select = cfgdi.input_type_select;
    assign supply_fault_mask = cfgdi.supply_fault_mask;
    assign overrange_protect_enable = cfgdi.overrange_protect_enable;
    assign overload_stretch_enable = cfgdi.overload_stretch_enable;
    assign overload_blanking_select = cfgdi.overload_blanking_select;

    // ============================================================
    // Watchdogs
    // ============================================================
    logic [WD_CNT_W-1:0] spi_timeout;    // Selected serial timeout
    logic [WD_CNT_W-1:0] sync_timeout;   // Selected sync timeout
    logic spi_wd_on;
    logic sync_prev, next_sync_prev;     // Edge detect on the sync pin
    logic sync_kick;

    // Timeout selection; sync falls back to the middle value when serial is off
    always_comb begin
        spi_wd_on = (cfg2.watchdog_timeout_select != WATCHDOG_TIMEOUT_SELECT_OFF);
        case (cfg2.watchdog_timeout_select)
            WATCHDOG_TIMEOUT_SELECT_SHORT: spi_timeout = WD_SHORT;
            WATCHDOG_TIMEOUT_SELECT_MID: spi_timeout = WD_MID;
            WATCHDOG_TIMEOUT_SELECT_LONG: spi_timeout = WD_LONG;
            default: spi_timeout = WD_MID;
        endcase
        sync_timeout = spi_wd_on ? spi_timeout : WD_MID;
        next_sync_prev = sync_input_pin;
        sync_kick = sync_input_pin != sync_prev;
    end

    // Sync pin history
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sync_prev <= 1'b0;
        end else begin
            sync_prev <= next_sync_prev;
        end
    end

    // Serial watchdog, restarted by every frame accepted for this chip
    dwc_watchdog u_spi_wd (
        .core_clk(core_clk),
        .rst(rst),
        .enable(spi_wd_on),
        .kick(commit),
        .timeout_cycles(spi_timeout),
        .expired(spi_watchdog_expired)
    );

    // Sync watchdog, restarted by any sync pin edge
    dwc_watchdog u_sync_wd (
        .core_clk(core_clk),
        .rst(rst),
        .enable(cfg2.sync_watchdog_enable),
        .kick(sync_kick),
        .timeout_cycles(sync_timeout),
        .expired(sync_watchdog_expired)
    );

    // ============================================================
    // Supply monitoring and channel level register
    // ============================================================
    logic main_ok;                       // Main supply above selected threshold
    logic [3:0] chan_ok;                 // Channel supplies above selected threshold
    logic next_supply_ok_n;
    logic [3:0] next_channel_on;

    // Threshold pick and level register source
    always_comb begin
        // High bit picks the higher comparator set for all supplies
        main_ok = cfg2.high_uv_threshold_enable ? main_above_high
                                                : main_above_normal;
        chan_ok = cfg2.high_uv_threshold_enable ? chan_above_high
                                                : chan_above_normal;
        next_supply_ok_n = !main_ok;
        next_channel_on = chan_ok & {4{main_ok}};
        // Fault view only while source select is set, so the bit's effect is gated
        if (cfgdi.level_register_source_select) begin
            next_level = ~chan_ok;
        end else begin
            next_level = channel_pin;
        end
    end

    // Supply status flops; channels held off until supplies are good
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            supply_ok_output_n <= 1'b1;
            channel_on <= 4'h0;
            level <= 4'h0;
        end else begin
            supply_ok_output_n <= next_supply_ok_n;
            channel_on <= next_channel_on;
            level <= next_level;
        end
    end

    // ============================================================
    // Checks
    // ============================================================
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence cfg2_write_s;
        commit && frame.write && frame.reg_addr == CFG2_OFS;
    endsequence

    spi_wd_off_a: assert property (cfg2.watchdog_timeout_select == WATCHDOG_TIMEOUT_SELECT_OFF ##1
        cfg2.watchdog_timeout_select == WATCHDOG_TIMEOUT_SELECT_OFF |-> !spi_watchdog_expired)
        else $error("serial watchdog active while disabled");
    spi_short_a: assert property (cfg2.watchdog_timeout_select == WATCHDOG_TIMEOUT_SELECT_SHORT
        |-> spi_timeout == WD_SHORT && sync_timeout == WD_SHORT)
        else $error("short timeout code not applied to both watchdogs");
    sync_off_a: assert property (!cfg2.sync_watchdog_enable ##1
        !cfg2.sync_watchdog_enable |-> !sync_watchdog_expired)
        else $error("sync watchdog flagged while disabled");
    sync_fixed_a: assert property (cfg2.watchdog_timeout_select == WATCHDOG_TIMEOUT_SELECT_OFF
        |-> sync_timeout == WD_MID)
        else $error("sync timeout not fixed when serial watchdog off");
    det_cur_write_a: assert property (cfg2_write_s |=>
        offstate_detect_current_select == $past(frame.data[DETCUR_POS +: 2]))
        else $error("detect current field not updated by write");
    shrt_thr_write_a: assert property (cfg2_write_s |=>
        short_supply_threshold_select == $past(frame.data[SHTTHR_POS +: 2]))
        else $error("short threshold field not updated by write");
    supply_good_a: assert property (cfg2.high_uv_threshold_enable && main_above_high
        |=> !supply_ok_output_n)
        else $error("supply ok not asserted with supply above high threshold");
    level_src_a: assert property (!cfgdi.level_register_source_select
        |=> level == $past(channel_pin))
        else $error("level register not showing pin levels");
    rsvd_zero_a: assert property (commit ##1 1'b1 |-> !cfgdi.reserved)
        else $error("reserved input config bit not zero");
    cfg_hold_a: assert property (!commit |=> cfg2 == $past(cfg2))
        else $error("config changed without a write");

endmodule : dwc_config_top

`default_nettype wire

// ==== logic/dwc_pkg.sv ====
// Purpose: Shared constants and types for the watchdog / supply config block
// Assumes: 200 MHz core clock, 16-bit addressed serial frames
// Notes:   Each offset, field position, reset value and time is named once here
`default_nettype none

package dwc_pkg;

    // ============================================================
    // Clock and watchdog timing
    // ============================================================
    localparam int unsigned CLK_KHZ = 200_000;       // Core clock, kHz
    localparam int unsigned WD_SHORT_MS = 200;       // Shortest watchdog timeout
    localparam int unsigned WD_MID_MS = 600;         // Middle timeout, also sync fallback
    localparam int unsigned WD_LONG_MS = 1200;       // Longest timeout (1.2 s)
    localparam int unsigned WD_SHORT_CYCLES = WD_SHORT_MS * CLK_KHZ;
    localparam int unsigned WD_MID_CYCLES = WD_MID_MS * CLK_KHZ;
    localparam int unsigned WD_LONG_CYCLES = WD_LONG_MS * CLK_KHZ;
    localparam int unsigned WD_CNT_W = 28;           // Holds 240M cycles

    // ============================================================
    // Register offsets (5-bit register address in the frame)
    // ============================================================
    localparam logic [4:0] LEVEL_OFS = 5'h02;        // Channel level register, read only
    localparam logic [4:0] CFG2_OFS = 5'h0b;         // Watchdog and detection config
    localparam logic [4:0] CFGDI_OFS = 5'h0c;        // Input and supply fault config

    // ============================================================
    // Field positions and reset values
    // ============================================================
    localparam int unsigned WATCHDOG_TIMEOUT_SELECT_POS = 6;            // Watchdog timeout select, 7:6
    localparam int unsigned DETCUR_POS = 4;          // Off-state detect current, 5:4
    localparam int unsigned SHTTHR_POS = 2;          // Short-to-supply threshold, 3:2
    localparam int unsigned SYNCEN_POS = 1;          // Sync watchdog enable
    localparam int unsigned HIGHUV_POS = 0;          // High undervoltage thresholds
    localparam int unsigned INTYPE_POS = 7;          // Input type select
    localparam int unsigned RSVD_POS = 6;            // Reserved, reads zero
    localparam int unsigned FMASK_POS = 5;           // Supply fault mask
    localparam int unsigned SRCSEL_POS = 4;          // Level register source select
    localparam int unsigned OVRPROT_POS = 3;         // Overrange protect enable
    localparam int unsigned OVLSTR_POS = 2;          // Overload stretch enable
    localparam int unsigned OVLBLK_POS = 0;          // Overload blanking select, 1:0
    localparam logic [7:0] CFG2_RESET = 8'h00;
    localparam logic [7:0] CFGDI_RESET = 8'h08;      // Overrange protect on by default

    // ============================================================
    // Types
    // ============================================================
    typedef enum logic [1:0] {
        WATCHDOG_TIMEOUT_SELECT_OFF = 2'b00,
        WATCHDOG_TIMEOUT_SELECT_SHORT = 2'b01,
        WATCHDOG_TIMEOUT_SELECT_MID = 2'b10,
        WATCHDOG_TIMEOUT_SELECT_LONG = 2'b11
    } dwc_watchdog_timeout_select_t;

    // Watchdog and detection config register image
    typedef struct packed {
        dwc_watchdog_timeout_select_t watchdog_timeout_select;
        logic [1:0] offstate_detect_current_select;
        logic [1:0] short_supply_threshold_select;
        logic sync_watchdog_enable;
        logic high_uv_threshold_enable;
    } dwc_cfg2_t;

    // Input and supply fault config register image
    typedef struct packed {
        logic input_type_select;
        logic reserved;
        logic supply_fault_mask;
        logic level_register_source_select;
        logic overrange_protect_enable;
        logic overload_stretch_enable;
        logic [1:0] overload_blanking_select;
    } dwc_cfgdi_t;

    // One serial frame, first bit on the line is the msb
    typedef struct packed {
        logic [1:0] chip;
        logic [4:0] reg_addr;
        logic write;
        logic [7:0] data;
    } dwc_frame_t;

endpackage : dwc_pkg

`default_nettype wire

// ==== logic/dwc_watchdog.sv ====
// Purpose: One watchdog timer with restart and sticky timeout status
// Assumes: Timeout may change at any time; a change takes effect on the next count
// Notes:   Disabling clears both counter and status
`default_nettype none

module dwc_watchdog
    import dwc_pkg::*;
(
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // Control
    input wire logic enable,
    input wire logic kick,
    input wire logic [WD_CNT_W-1:0] timeout_cycles,
    // Status
    output logic expired
);

    // ============================================================
    // Counter and status
    // ============================================================
    logic [WD_CNT_W-1:0] count;          // Cycles since last kick
    logic [WD_CNT_W-1:0] next_count;
    logic next_expired;
    logic reach;                         // Timeout reached this cycle

    // Next-state: count up, restart on kick, flag on reach
    always_comb begin
        // A saturated count must not pin the status: restarting an expired timer clears it
        reach = (count >= timeout_cycles - WD_CNT_W'(1)) && !(kick && expired);
        next_count = count;
        next_expired = expired;
        if (!enable) begin
            // Disabled: status and timeout both off
            next_count = '0;
            next_expired = 1'b0;
        end else begin
            if (kick) begin
                next_count = '0;
                next_expired = 1'b0;
            end else if (!reach) begin
                next_count = count + WD_CNT_W'(1);
            end
            // Reaching the timeout beats a kick in the same cycle
            if (reach) begin
                next_expired = 1'b1;
            end
        end
    end

    // Registers only
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            count <= '0;
            expired <= 1'b0;
        end else begin
            count <= next_count;
            expired <= next_expired;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    wd_expire_a: assert property (enable && reach |=> expired)
        else $error("watchdog did not flag expiry at timeout");
    wd_disable_a: assert property (!enable |=> !expired && count == '0)
        else $error("disabled watchdog still counting or flagged");
    wd_restart_a: assert property (enable && kick && !reach |=> !expired)
        else $error("restart did not clear watchdog status");

endmodule : dwc_watchdog

`default_nettype wire

// ==== bench/dwc_host_model.sv ====
// Purpose: Host side of the addressed serial port
// Assumes: 16-bit frames, msb first, sclk half period of 3 core cycles
// Notes:   Lines move only on core_clk falls; sclk stands low between frames
`default_nettype none

module dwc_host_model (
    // Clock
    input wire logic core_clk,
    // Serial lines
    output logic spi_cs_n,
    output logic spi_sclk,
    output logic spi_mosi,
    input wire logic miso_line
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle lines
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_mosi = 1'b0;
    end

    // One frame; reply bits taken just before rises 9 to 16
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rd);
        rd = 8'h00;
        spi_cs_n = 1'b0;
        repeat (2) @(negedge core_clk);
        for (int i = 15; i >= 0; i--) begin
            spi_mosi = frame[i];
            repeat (3) @(negedge core_clk);
            if (i < 8) rd[i] = miso_line;
            spi_sclk = 1'b1;
            repeat (3) @(negedge core_clk);
            spi_sclk = 1'b0;
        end
        repeat (3) @(negedge core_clk);
        spi_cs_n = 1'b1;
        // Released data line must not keep the last bit
        spi_mosi = ~spi_mosi;
        repeat (3) @(negedge core_clk);
    endtask : xfer
endmodule : dwc_host_model

`default_nettype wire

// ==== bench/tb_top.sv ====
// Purpose: Self-checking bench for the watchdog and supply config block
// Assumes: Watchdog times cut to 20/60/120 cycles; chip address 01
// Notes:   Idle miso reads high, as through a pull-up
`default_nettype none

module tb_top
    import dwc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic core_clk = 1'b0;
    logic rst, cs_n, sclk, mosi, miso, oe_n, miso_line, sync, main_n, main_h;
    logic sok_n, spi_exp, sync_exp, huv, ityp, fmask, ovr, ovls;
    logic [3:0] chan_n, chan_h, pins, chan_on;
    logic [1:0] det, sht, ovlb;
    logic [7:0] rd, v, w;
    int mismatches = 0;
    int cmp_count = 0;
    int seed = 32'h3fc9ea96;
    int cycles = 0;
    int t, ts;

    always #2.5 core_clk = ~core_clk;
    // Pull-up on the shared reply line
    assign miso_line = oe_n ? 1'b1 : miso;

    // ============================================================
    // Instances
    // ============================================================
    dwc_config_top #(.WD_SHORT(28'd20), .WD_MID(28'd60), .WD_LONG(28'd120)) dwc_config_top_inst (
        .core_clk(core_clk), .rst(rst), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
        .spi_miso(miso), .spi_miso_oe_n(oe_n), .chip_addr(2'b01), .sync_input_pin(sync),
        .main_above_normal(main_n), .main_above_high(main_h), .chan_above_normal(chan_n),
        .chan_above_high(chan_h), .channel_pin(pins), .supply_ok_output_n(sok_n),
        .channel_on(chan_on), .spi_watchdog_expired(spi_exp),
        .sync_watchdog_expired(sync_exp), .offstate_detect_current_select(det),
        .short_supply_threshold_select(sht), .high_uv_threshold_enable(huv),
        .input_type_select(ityp), .supply_fault_mask(fmask), .overrange_protect_enable(ovr),
        .overload_stretch_enable(ovls), .overload_blanking_select(ovlb));
    dwc_host_model host_inst (.core_clk(core_clk), .spi_cs_n(cs_n), .spi_sclk(sclk),
        .spi_mosi(mosi), .miso_line(miso_line));

    // ============================================================
    // Checks and helpers
    // ============================================================
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic xf(input logic [1:0] chip, input logic [4:0] a, input logic wr,
                      input logic [7:0] d);
        host_inst.xfer({chip, a, wr, d}, rd);
    endtask : xf

    // Supply outputs from the comparator set chosen by the threshold bit
    function automatic logic [7:0] exp_sup(input logic h);
        logic m;
        m = h ? main_h : main_n;
        return {3'b000, ~m, m ? (h ? chan_h : chan_n) : 4'h0};
    endfunction : exp_sup

    task automatic results;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : results

    // Hang guard
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            results();
        end
    end

    // ============================================================
    // Main sequence
    // ============================================================
    initial begin
        {rst, sync, main_n, main_h, chan_n, chan_h, pins} = {1'b1, 15'h0};
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        @(negedge core_clk);
        xf(2'b01, CFG2_OFS, 1'b0, 8'h00);
        chk(rd, CFG2_RESET);
        xf(2'b01, CFGDI_OFS, 1'b0, 8'h00);
        chk(rd, CFGDI_RESET);
        for (int k = 0; k < 6; k++) begin
            {main_n, main_h, chan_n, chan_h, pins} = 14'($random(seed));
            v = 8'($random(seed));
            w = (k == 0) ? 8'hff : 8'($random(seed));
            xf(2'b01, CFG2_OFS, 1'b1, v);
            // Other chip address must leave the register alone
            xf(2'b10, CFG2_OFS, 1'b1, ~v);
            xf(2'b01, CFG2_OFS, 1'b0, 8'h00);
            chk(rd, v);
            chk({3'b000, det, sht, huv}, {3'b000, v[5:2], v[0]});
            chk({3'b000, sok_n, chan_on}, exp_sup(v[0]));
            xf(2'b01, CFGDI_OFS, 1'b1, w);
            xf(2'b01, CFGDI_OFS, 1'b0, 8'h00);
            chk(rd, w & 8'hbf);
            // Source select (bit 4) has no pin of its own, so it is skipped here
            chk({2'b00, ityp, fmask, ovr, ovls, ovlb}, {2'b00, w[7], w[5], w[3:0]});
            xf(2'b01, LEVEL_OFS, 1'b0, 8'h00);
            chk({4'h0, rd[3:0]}, {4'h0, w[4] ? ~(v[0] ? chan_h : chan_n) : pins});
        end
        // Every timeout code with the sync watchdog off and on
        for (int c = 0; c < 8; c++) begin
            xf(2'b01, CFG2_OFS, 1'b1, {c[1:0], 4'h0, c[2], 1'b0});
            sync = ~sync;
            t = (c[1:0] == 2'b01) ? 20 : (c[1:0] == 2'b10) ? 60 : (c[1:0] == 2'b11) ? 120 : 0;
            ts = !c[2] ? 0 : (t == 0) ? 60 : t;
            for (int n = 1; n < 130; n++) begin
                @(negedge core_clk);
                if (t == 0 || n < t - 3) chk(8'(spi_exp), 8'h00);
                else if (n > t + 3) chk(8'(spi_exp), 8'h01);
                if (ts == 0 || n < ts - 3) chk(8'(sync_exp), 8'h00);
                else if (n > ts + 3) chk(8'(sync_exp), 8'h01);
            end
        end
        results();
    end
endmodule : tb_top

`default_nettype wire
